// >>> inc/register_data_router_pkg.sv
// Notes on behaviour
// - every store register is 16 bits: data, configuration, status, errors
// - an 8-bit value uses one register, a 32-bit value two registers
// - words are kept little-endian and ports see that byte order
// - register numbers are one-based, 0x0001 up to 0x10000, small subset built
// - each consumer output area has up to 8 word mapping entries with own length
// - word mapping targets pack back to back from the area's lowest register
// - each word entry copies an equal-length block from any input area
// - length plus 0x8000 swaps high and low byte of every copied register
// - up to 16 bitwise entries copy runs of consecutive bits
// - a bitwise entry length is in bits, at most 1024
// - bitwise target is any output register and bit 0 to 15, not adjacent
// - bitwise source is an input register number plus a start bit
// - each cycle runs all word entries first, then all bitwise entries
// - overlapping targets are not blocked; later copies overwrite earlier ones
// - each producer port keeps its own validity period
// - fresh data restarts the producer timer; expiry marks its data invalid
// - invalid source writes consumer fallback: all zero, all ones or keep last
// - validity periods and fallback policies survive a restart
// - mapping changes take effect only after a restart
// - serial data port input spans 0x1401 to 0x1410; sync serial input at 0x1001
// - fieldbus output area begins at register 0x2801
package register_data_router_pkg;

  // ----------------------------------------
  // store geometry
  // ----------------------------------------
  localparam int unsigned AREAS       = 6;
  localparam int unsigned AREA_LEN    = 16;
  localparam int unsigned PORTS       = 3;
  localparam int unsigned STORE_WORDS = AREAS * AREA_LEN;

  // area order: serial in/out, sync serial in/out, fieldbus in/out
  localparam logic [AREAS-1:0][15:0] AREA_BASE = {
    16'h2801, 16'h2001, 16'h1101, 16'h1001, 16'h1501, 16'h1401
  };

  // ----------------------------------------
  // configuration block
  // ----------------------------------------
  localparam logic [15:0] CFG_BASE     = 16'h3001;
  localparam int unsigned WMAP_ENTRIES = 8;
  localparam int unsigned XMAP_ENTRIES = 16;
  localparam int unsigned XMAP_OFS     = 48;
  localparam int unsigned XMAP_STRIDE  = 5;
  localparam int unsigned PERIOD_OFS   = 128;
  localparam int unsigned FBK_OFS      = 131;
  localparam int unsigned CFG_WORDS    = 134;
  localparam int unsigned SWAP_BIT     = 15;
  localparam logic [10:0] MAX_BITS     = 11'h400;

  localparam logic [15:0] CTRL_RESTART = 16'h3101;
  localparam logic [15:0] STATUS_REG   = 16'h3102;

  localparam logic [1:0]  FB_ZERO      = 2'h0;
  localparam logic [1:0]  FB_ONES      = 2'h1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned VALID_UNIT_NS   = 1000000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned TICK_CYCLES_DEF = VALID_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } regbus_s;

  typedef enum logic {PH_WORD, PH_BIT} phase_e;

  typedef struct packed {
    logic [STORE_WORDS-1:0][15:0] store;
    logic [CFG_WORDS-1:0][15:0]   cfg;
    logic [CFG_WORDS-1:0][15:0]   act;
    logic [PORTS-1:0][15:0]       tmr;
    logic [PORTS-1:0]             valid;
    logic [16:0]                  div;
    phase_e                       phase;
    logic [1:0]                   cons;
    logic [2:0]                   ent;
    logic [3:0]                   ext;
    logic [10:0]                  k;
    logic [4:0]                   dp;
    logic [15:0]                  rdata;
    logic                         done;
  } st_s;

  localparam st_s ST_RESET = '0;

endpackage : register_data_router_pkg

// >>> logic/register_data_router.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module register_data_router #(
  parameter int unsigned TICK_CYCLES = register_data_router_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // register port
  input  wire register_data_router_pkg::regbus_s bus,
  output logic [15:0]                            rdata,
  // status
  output logic [register_data_router_pkg::PORTS-1:0] producerValid,
  output logic                                   cycleDone
);
  import register_data_router_pkg::*;

  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  st_s         st;
  st_s         next_st;

  logic [7:0]  hit;
  logic [7:0]  sHit;
  logic [7:0]  dHit;
  logic [15:0] cfgOff;
  logic        cfgHit;
  logic        restart;
  logic        tick;
  logic [15:0] per;
  logic [15:0] lenW;
  logic [10:0] lenB;
  logic [15:0] srcWord;
  logic [15:0] wordData;
  logic        wordWr;
  logic        wordSwap;
  logic        fbActive;
  logic [1:0]  fbMode;
  logic [6:0]  dstIdx;
  logic [15:0] sPos;
  logic [15:0] dPos;
  logic        bitVal;
  logic        bitWr;
  int unsigned xb;

  // ----------------------------------------
  // area decode: {hit, area, offset}
  // ----------------------------------------
  function automatic logic [7:0] areaIdx(input logic [15:0] r);
    logic [15:0] d;
    d = '0;
    areaIdx = '0;
    for (int a = 0; a < AREAS; a++) begin
      d = r - AREA_BASE[a];
      if (r >= AREA_BASE[a] && d < 16'(AREA_LEN)) begin
        areaIdx = {1'b1, 3'(a), d[3:0]};
      end
    end
  endfunction : areaIdx

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st  = st;
    next_st.done  = 1'b0;
    next_st.rdata = '0;
    restart  = 1'b0;
    per      = '0;
    lenW     = '0;
    lenB     = '0;
    srcWord  = '0;
    wordData = '0;
    wordWr   = 1'b0;
    wordSwap = 1'b0;
    fbActive = 1'b0;
    fbMode   = FB_ZERO;
    dstIdx   = '0;
    sPos     = '0;
    dPos     = '0;
    sHit     = '0;
    dHit     = '0;
    bitVal   = 1'b0;
    bitWr    = 1'b0;
    xb       = XMAP_OFS + XMAP_STRIDE * 32'(st.ext);

    // time base for validity periods
    tick = (st.div == 17'(TICK_CYCLES - 1));
    next_st.div = tick ? '0 : st.div + 17'h1;

    // per-producer validity timers
    for (int p = 0; p < PORTS; p++) begin
      per = st.cfg[PERIOD_OFS + p];
      if (per == '0) begin
        next_st.valid[p] = 1'b1;
      end else if (tick && st.valid[p]) begin
        next_st.tmr[p] = st.tmr[p] + 16'h1;
        if (next_st.tmr[p] >= per) begin
          next_st.valid[p] = 1'b0;
        end
      end
    end

    // register port decode
    hit    = areaIdx(bus.addr);
    cfgOff = bus.addr - CFG_BASE;
    cfgHit = bus.addr >= CFG_BASE && cfgOff < 16'(CFG_WORDS);

    if (bus.wr) begin
      if (hit[7] && !hit[4]) begin
        // input area: words stored as given, little-endian
        next_st.store[hit[6:0]] = bus.wdata;
        next_st.tmr[hit[6:5]]   = '0;
        next_st.valid[hit[6:5]] = 1'b1;
      end else if (cfgHit) begin
        next_st.cfg[cfgOff[7:0]] = bus.wdata;
      end else if (bus.addr == CTRL_RESTART && bus.wdata[0]) begin
        restart = 1'b1;
      end
    end

    if (bus.rd) begin
      if (hit[7]) begin
        next_st.rdata = st.store[hit[6:0]];
      end else if (cfgHit) begin
        next_st.rdata = st.cfg[cfgOff[7:0]];
      end else if (bus.addr == STATUS_REG) begin
        next_st.rdata = {12'h000, st.phase == PH_BIT, st.valid};
      end
    end

    // ----------------------------------------
    // routing engine, one copy per clock
    // ----------------------------------------
    unique case (st.phase)
      PH_WORD: begin
        lenW = st.act[{st.cons, st.ent, 1'b1}];
        if (lenW[14:0] == '0 || 15'(st.k) >= lenW[14:0]
            || st.dp == 5'(AREA_LEN)) begin
          next_st.k   = '0;
          next_st.ent = st.ent + 3'h1;
          if (st.ent == 3'(WMAP_ENTRIES - 1)) begin
            next_st.dp   = '0;
            next_st.cons = st.cons + 2'h1;
            if (st.cons == 2'(PORTS - 1)) begin
              next_st.cons  = '0;
              next_st.ext   = '0;
              next_st.phase = PH_BIT;
            end
          end
        end else begin
          sHit     = areaIdx(st.act[{st.cons, st.ent, 1'b0}] + 16'(st.k));
          srcWord  = st.store[sHit[6:0]];
          fbMode   = st.cfg[FBK_OFS + 32'(st.cons)][1:0];
          fbActive = !st.valid[sHit[6:5]];
          wordSwap = lenW[SWAP_BIT];
          if (fbActive) begin
            wordData = (fbMode == FB_ONES) ? 16'hffff : 16'h0000;
          end else if (wordSwap) begin
            wordData = {srcWord[7:0], srcWord[15:8]};
          end else begin
            wordData = srcWord;
          end
          // keep-last policy leaves the target alone
          wordWr = sHit[7] && !sHit[4] && !(fbActive && fbMode[1]);
          dstIdx = {st.cons, 1'b1, st.dp[3:0]};
          if (wordWr) begin
            next_st.store[dstIdx] = wordData;
          end
          next_st.dp = st.dp + 5'h1;
          next_st.k  = st.k + 11'h1;
        end
      end
      PH_BIT: begin
        lenB = st.act[xb + 4][10:0];
        if (lenB == '0 || st.k >= lenB || st.act[xb + 4] > 16'(MAX_BITS)) begin
          next_st.k   = '0;
          next_st.ext = st.ext + 4'h1;
          if (st.ext == 4'(XMAP_ENTRIES - 1)) begin
            next_st.phase = PH_WORD;
            next_st.done  = 1'b1;
          end
        end else begin
          sPos = 16'(st.act[xb + 1][3:0]) + 16'(st.k);
          dPos = 16'(st.act[xb + 3][3:0]) + 16'(st.k);
          sHit = areaIdx(st.act[xb] + (sPos >> 4));
          dHit = areaIdx(st.act[xb + 2] + (dPos >> 4));
          if (dHit[7]) begin
            fbMode = st.cfg[FBK_OFS + 32'(dHit[6:5])][1:0];
          end
          fbActive = !st.valid[sHit[6:5]];
          bitVal   = fbActive ? (fbMode == FB_ONES)
                              : st.store[sHit[6:0]][sPos[3:0]];
          bitWr    = sHit[7] && !sHit[4] && dHit[7] && dHit[4]
                     && !(fbActive && fbMode[1]);
          if (bitWr) begin
            next_st.store[dHit[6:0]][dPos[3:0]] = bitVal;
          end
          next_st.k = st.k + 11'h1;
        end
      end
    endcase

    // restart loads mappings; periods and policies stay
    if (restart) begin
      next_st.act   = st.cfg;
      next_st.phase = PH_WORD;
      next_st.cons  = '0;
      next_st.ent   = '0;
      next_st.ext   = '0;
      next_st.k     = '0;
      next_st.dp    = '0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata         = st.rdata;
  assign producerValid = st.valid;
  assign cycleDone     = st.done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence restartReq;
    bus.wr && bus.addr == CTRL_RESTART && bus.wdata[0];
  endsequence

  sequence inputWrite;
    bus.wr && hit[7] && !hit[4];
  endsequence

  sequence wordPhaseEnd;
    st.phase == PH_WORD && st.cons == 2'h2 && st.ent == 3'h7;
  endsequence

  chk_restart_load: assert property (
    restartReq |=> st.act == $past(st.cfg) && st.phase == PH_WORD && st.k == '0)
    else $error("mappings not loaded on restart");

  chk_cfg_deferred: assert property (
    bus.wr && cfgHit |=> $stable(st.act))
    else $error("mapping changed without restart");

  chk_input_store: assert property (
    inputWrite |=> st.store[$past(hit[6:0])] == $past(bus.wdata))
    else $error("input register not stored");

  chk_fresh_valid: assert property (
    inputWrite |=> st.valid[$past(hit[6:5])] && st.tmr[$past(hit[6:5])] == '0)
    else $error("fresh data did not restart timer");

  chk_timeout_one: assert property (
    st.valid[0] && st.cfg[PERIOD_OFS] != '0 && tick
    && st.tmr[0] == st.cfg[PERIOD_OFS] - 16'h1
    && !(bus.wr && hit[7] && hit[6:4] == 3'h0) |=> !st.valid[0])
    else $error("producer not invalid after period");

  chk_period_off: assert property (
    rst_n && st.cfg[PERIOD_OFS + 1] == '0 |=> st.valid[1])
    else $error("zero period still timed out");

  chk_swap_word: assert property (
    wordWr && wordSwap && !fbActive
    |=> st.store[$past(dstIdx)] == {$past(srcWord[7:0]), $past(srcWord[15:8])})
    else $error("byte swap not applied");

  chk_fallback_fill: assert property (
    wordWr && fbActive
    |=> st.store[$past(dstIdx)] == (($past(fbMode) == FB_ONES) ? 16'hffff : 16'h0000))
    else $error("fallback value not written");

  chk_word_first: assert property (
    st.phase == PH_BIT && $past(st.phase) == PH_WORD |-> $past(st.cons) == 2'h2
    && $past(st.ent) == 3'h7)
    else $error("bitwise phase entered early");

  chk_word_to_bit: assert property (
    wordPhaseEnd ##0 (lenW[14:0] == '0 || 15'(st.k) >= lenW[14:0]) && !restart
    |=> st.phase == PH_BIT && st.ext == '0)
    else $error("bitwise phase not started");

  chk_bit_limit: assert property (
    st.phase == PH_BIT && st.act[xb + 4] > 16'(MAX_BITS) && !restart |=> st.k == '0)
    else $error("over-long bit entry not skipped");

  chk_status_read: assert property (
    bus.rd && bus.addr == STATUS_REG |=> rdata[2:0] == $past(st.valid))
    else $error("status read wrong");

  sequence skipEntry;
    rst_n && st.phase == PH_WORD && lenW[14:0] == '0 && !restart;
  endsequence

  sequence passEnd;
    cycleDone;
  endsequence

  chk_rdata_idle: assert property (
    !bus.rd |=> rdata == '0)
    else $error("read data not cleared");

  chk_done_single: assert property (
    passEnd |=> !cycleDone)
    else $error("pass end longer than one cycle");

  chk_pass_wrap: assert property (
    passEnd |-> st.phase == PH_WORD && st.ext == '0 && st.cons == '0)
    else $error("next pass not at word phase");

  chk_entry_skip: assert property (
    skipEntry |=> st.k == '0 && st.ent == $past(st.ent) + 3'h1)
    else $error("empty entry not skipped");

  chk_word_copy: assert property (
    wordWr && !wordSwap && !fbActive |=> st.store[$past(dstIdx)] == $past(srcWord))
    else $error("word not copied");

  chk_pack_order: assert property (
    wordWr && !restart |=> st.dp == $past(st.dp) + 5'h1)
    else $error("word target not packed");

  chk_bit_copy: assert property (
    bitWr |=> st.store[$past(dHit[6:0])][$past(dPos[3:0])] == $past(bitVal))
    else $error("bit not copied");

  chk_timer_hold: assert property (
    !tick && !(bus.wr && hit[7] && !hit[4]) |=> st.tmr == $past(st.tmr))
    else $error("timer moved between ticks");

endmodule : register_data_router

// >>> sim/port_agent.sv
`timescale 1ns/1ps
module port_agent (
  // clock
  input  wire logic                              clk,
  // register port
  output register_data_router_pkg::regbus_s      bus,
  input  wire logic [15:0]                       rdata
);
  import register_data_router_pkg::*;

  // ----------------------------------------
  // bus master cycles
  // ----------------------------------------
  initial bus = '0;

  // released lines show the inverse, never the last value
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
    bus.addr  <= ~a;
    bus.wdata <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    bus.addr <= ~a;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : port_agent

// >>> sim/register_data_router_test.sv
`timescale 1ns/1ps
module register_data_router_test;
  import register_data_router_pkg::*;
  localparam int unsigned TICK = 4;
  logic                 clk;
  logic                 rst_n;
  regbus_s              bus;
  logic [15:0]          rdata;
  logic [PORTS-1:0]     producerValid;
  logic                 cycleDone;
  int                   nFail;
  int                   nTests;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  register_data_router #(.TICK_CYCLES(TICK)) register_data_router_inst (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .producerValid(producerValid), .cycleDone(cycleDone));
  port_agent port_agent_inst (.clk(clk), .bus(bus), .rdata(rdata));

  // ----------------------------------------
  // compares and helpers
  // ----------------------------------------
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag

  task automatic expect_reg(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    port_agent_inst.rd_reg(a, d);
    check_word(d, exp);
  endtask : expect_reg

  // cycles up to the next end-of-pass pulse
  task automatic pass_len(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cycleDone !== 1'b1 && n < 500);
    if (n >= 500) begin
      nFail++;
      $display("unexpected stall at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask : pass_len

  task automatic full_pass();
    int n;
    pass_len(n);
    pass_len(n);
  endtask : full_pass

  task automatic restart();
    port_agent_inst.wr_reg(CTRL_RESTART, 16'h0001);
    full_pass();
  endtask : restart

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    int n;
    repeat (2) @(negedge clk);
    for (int p = 0; p < PORTS; p++) begin
      check_flag(producerValid[p], 1'b1);
    end
    pass_len(n);
    pass_len(n);
    check_word(n[15:0], 16'h0028);
    $display("test reset done");
  endtask : test_reset

  task automatic test_bus();
    port_agent_inst.wr_reg(CFG_BASE, 16'ha55a);
    expect_reg(CFG_BASE, 16'ha55a);
    repeat (2) @(negedge clk);
    check_word(rdata, 16'h0000);
    expect_reg(16'h0500, 16'h0000);
    port_agent_inst.wr_reg(16'h2801, 16'hbeef);
    expect_reg(16'h2801, 16'h0000);
    port_agent_inst.wr_reg(CFG_BASE, 16'h0000);
    $display("test bus done");
  endtask : test_bus

  task automatic test_map();
    logic [15:0] cfg [14];
    cfg = '{16'h1401, 16'h0003, 16'h1001, 16'h8002, 16'h1401,
            16'h0004, 16'h2801, 16'h0000, 16'h0008, 16'h1401,
            16'h0000, 16'h2806, 16'h0000, 16'h0401};
    port_agent_inst.wr_reg(16'h1401, 16'h1234);
    port_agent_inst.wr_reg(16'h1402, 16'h5678);
    port_agent_inst.wr_reg(16'h1403, 16'h9abc);
    port_agent_inst.wr_reg(16'h1001, 16'h0f1e);
    port_agent_inst.wr_reg(16'h1002, 16'h2d3c);
    // fieldbus consumer entries 0 and 1, then extended entries 0 and 1
    for (int i = 0; i < 4; i++) begin
      port_agent_inst.wr_reg(16'h3021 + 16'(i), cfg[i]);
    end
    for (int i = 0; i < 10; i++) begin
      port_agent_inst.wr_reg(16'h3031 + 16'(i), cfg[i + 4]);
    end
    full_pass();
    expect_reg(16'h2801, 16'h0000);
    restart();
    expect_reg(16'h2801, 16'h1223);
    expect_reg(16'h2802, 16'h5678);
    expect_reg(16'h2803, 16'h9abc);
    expect_reg(16'h2804, 16'h1e0f);
    expect_reg(16'h2805, 16'h3c2d);
    expect_reg(16'h2806, 16'h0000);
    $display("test map done");
  endtask : test_map

  task automatic test_timeout();
    logic [15:0] d;
    port_agent_inst.wr_reg(16'h3086, {14'h0000, FB_ONES});
    port_agent_inst.wr_reg(16'h3081, 16'h0002);
    port_agent_inst.wr_reg(16'h1401, 16'h1234);
    @(negedge clk);
    check_flag(producerValid[0], 1'b1);
    repeat (40) @(negedge clk);
    check_flag(producerValid[0], 1'b0);
    check_flag(producerValid[1], 1'b1);
    port_agent_inst.rd_reg(STATUS_REG, d);
    check_word({13'h0, d[2:0]}, 16'h0006);
    full_pass();
    expect_reg(16'h2801, 16'hffff);
    expect_reg(16'h2803, 16'hffff);
    expect_reg(16'h2804, 16'h1e0f);
    restart();
    expect_reg(16'h3081, 16'h0002);
    expect_reg(16'h3086, {14'h0000, FB_ONES});
    port_agent_inst.wr_reg(16'h3081, 16'h0000);
    repeat (3) @(negedge clk);
    check_flag(producerValid[0], 1'b1);
    full_pass();
    expect_reg(16'h2801, 16'h1223);
    $display("test timeout done");
  endtask : test_timeout

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic finalReport();
    $display("tests %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finalReport

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    finalReport();
  end

  initial begin
    nFail  = 0;
    nTests = 0;
    rst_n  = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_bus();
    test_map();
    test_timeout();
    finalReport();
  end
endmodule : register_data_router_test
